// ---- cqt_map.svh ----
`ifndef CQT_MAP_SVH
`define CQT_MAP_SVH

`define CQT_OFS_CORE_MIN      9'h01B
`define CQT_OFS_CORE_MAX      9'h01C
`define CQT_OFS_PROG_MIN      9'h01D
`define CQT_OFS_PROG_MAX      9'h01E
`define CQT_OFS_WORD_TYP      9'h01F
`define CQT_OFS_BUF_TYP       9'h020
`define CQT_OFS_BLK_TYP       9'h021
`define CQT_OFS_CHIP_TYP      9'h022
`define CQT_OFS_WORD_MAX      9'h023
`define CQT_OFS_BUF_MAX       9'h024
`define CQT_OFS_BLK_MAX       9'h025
`define CQT_OFS_CHIP_MAX      9'h026
`define CQT_OFS_SIZE          9'h027
`define CQT_OFS_IFC_LO        9'h028
`define CQT_OFS_IFC_HI        9'h029
`define CQT_OFS_WBUF_LO       9'h02A
`define CQT_OFS_WBUF_HI       9'h02B
`define CQT_OFS_REGIONS       9'h02C
`define CQT_OFS_R1_CNT_LO     9'h02D
`define CQT_OFS_R1_CNT_HI     9'h02E
`define CQT_OFS_R1_SIZE_LO    9'h02F
`define CQT_OFS_R1_SIZE_HI    9'h030
`define CQT_OFS_R2_CNT_LO     9'h031
`define CQT_OFS_R2_CNT_HI     9'h032
`define CQT_OFS_R2_SIZE_LO    9'h033
`define CQT_OFS_R2_SIZE_HI    9'h034
`define CQT_OFS_RSVD_FIRST    9'h035
`define CQT_OFS_RSVD_LAST     9'h038
`define CQT_OFS_SIG0          9'h10A
`define CQT_OFS_SIG1          9'h10B
`define CQT_OFS_SIG2          9'h10C
`define CQT_OFS_VER_MAJ       9'h10D
`define CQT_OFS_VER_MIN       9'h10E
`define CQT_OFS_FEAT0         9'h10F
`define CQT_OFS_FEAT1         9'h110
`define CQT_OFS_FEAT2         9'h111
`define CQT_OFS_FEAT3         9'h112

`define CQT_VAL_CORE_MIN      8'h17
`define CQT_VAL_CORE_MAX      8'h20
`define CQT_VAL_PROG_MIN      8'h85
`define CQT_VAL_PROG_MAX      8'h95
`define CQT_VAL_WORD_TYP      8'h04
`define CQT_VAL_BUF_TYP       8'h09
`define CQT_VAL_BLK_TYP       8'h0A
`define CQT_VAL_CHIP_TYP      8'h00
`define CQT_VAL_WORD_MAX      8'h04
`define CQT_VAL_BUF_MAX       8'h04
`define CQT_VAL_BLK_MAX       8'h02
`define CQT_VAL_CHIP_MAX      8'h00
`define CQT_VAL_SIZE          8'h18
`define CQT_VAL_IFC_LO        8'h01
`define CQT_VAL_IFC_HI        8'h01
`define CQT_VAL_WBUF_LO       8'h06
`define CQT_VAL_WBUF_HI       8'h00
`define CQT_VAL_REGIONS       8'h02
`define CQT_VAL_R1_CNT_LO     8'h7E
`define CQT_VAL_R1_CNT_HI     8'h00
`define CQT_VAL_R1_SIZE_LO    8'h00
`define CQT_VAL_R1_SIZE_HI    8'h02
`define CQT_VAL_R2_CNT_LO     8'h03
`define CQT_VAL_R2_CNT_HI     8'h00
`define CQT_VAL_R2_SIZE_LO    8'h80
`define CQT_VAL_R2_SIZE_HI    8'h00
`define CQT_VAL_RSVD          8'h00
`define CQT_VAL_SIG0          8'h50
`define CQT_VAL_SIG1          8'h52
`define CQT_VAL_SIG2          8'h49
`define CQT_VAL_VER_MAJ       8'h31
`define CQT_VAL_VER_MIN       8'h33
`define CQT_VAL_FEAT0         8'hE6
`define CQT_VAL_FEAT1         8'h03
`define CQT_VAL_FEAT2         8'h00
`define CQT_VAL_FEAT3         8'h00

`define CQT_CMD_QUERY         8'h98
`define CQT_CMD_READ_ARRAY    8'hFF

`endif

// ---- cqt_pkg.sv ----
package cqt_pkg;
   typedef logic [8:0]  cqt_ofs_t;
   typedef logic [7:0]  cqt_byte_t;
   typedef logic [15:0] cqt_word_t;
   typedef enum logic [1:0] {
      CQT_ARRAY = 2'b01,
      CQT_QUERY = 2'b10
   } cqt_mode_t;
endpackage : cqt_pkg

// ---- cqt_rom.sv ----
`timescale 1ns/1ns
`include "cqt_map.svh"
module cqt_rom
   import cqt_pkg::*;
(
   input  wire cqt_ofs_t  ofs,
   output cqt_byte_t      data
);
   always_comb begin
      case (ofs)
         `CQT_OFS_CORE_MIN:   data = `CQT_VAL_CORE_MIN;
         `CQT_OFS_CORE_MAX:   data = `CQT_VAL_CORE_MAX;
         `CQT_OFS_PROG_MIN:   data = `CQT_VAL_PROG_MIN;
         `CQT_OFS_PROG_MAX:   data = `CQT_VAL_PROG_MAX;
         `CQT_OFS_WORD_TYP:   data = `CQT_VAL_WORD_TYP;
         `CQT_OFS_BUF_TYP:    data = `CQT_VAL_BUF_TYP;
         `CQT_OFS_BLK_TYP:    data = `CQT_VAL_BLK_TYP;
         `CQT_OFS_CHIP_TYP:   data = `CQT_VAL_CHIP_TYP;
         `CQT_OFS_WORD_MAX:   data = `CQT_VAL_WORD_MAX;
         `CQT_OFS_BUF_MAX:    data = `CQT_VAL_BUF_MAX;
         `CQT_OFS_BLK_MAX:    data = `CQT_VAL_BLK_MAX;
         `CQT_OFS_CHIP_MAX:   data = `CQT_VAL_CHIP_MAX;
         `CQT_OFS_SIZE:       data = `CQT_VAL_SIZE;
         `CQT_OFS_IFC_LO:     data = `CQT_VAL_IFC_LO;
         `CQT_OFS_IFC_HI:     data = `CQT_VAL_IFC_HI;
         `CQT_OFS_WBUF_LO:    data = `CQT_VAL_WBUF_LO;
         `CQT_OFS_WBUF_HI:    data = `CQT_VAL_WBUF_HI;
         `CQT_OFS_REGIONS:    data = `CQT_VAL_REGIONS;
         `CQT_OFS_R1_CNT_LO:  data = `CQT_VAL_R1_CNT_LO;
         `CQT_OFS_R1_CNT_HI:  data = `CQT_VAL_R1_CNT_HI;
         `CQT_OFS_R1_SIZE_LO: data = `CQT_VAL_R1_SIZE_LO;
         `CQT_OFS_R1_SIZE_HI: data = `CQT_VAL_R1_SIZE_HI;
         `CQT_OFS_R2_CNT_LO:  data = `CQT_VAL_R2_CNT_LO;
         `CQT_OFS_R2_CNT_HI:  data = `CQT_VAL_R2_CNT_HI;
         `CQT_OFS_R2_SIZE_LO: data = `CQT_VAL_R2_SIZE_LO;
         `CQT_OFS_R2_SIZE_HI: data = `CQT_VAL_R2_SIZE_HI;
         `CQT_OFS_SIG0:       data = `CQT_VAL_SIG0;
         `CQT_OFS_SIG1:       data = `CQT_VAL_SIG1;
         `CQT_OFS_SIG2:       data = `CQT_VAL_SIG2;
         `CQT_OFS_VER_MAJ:    data = `CQT_VAL_VER_MAJ;
         `CQT_OFS_VER_MIN:    data = `CQT_VAL_VER_MIN;
         `CQT_OFS_FEAT0:      data = `CQT_VAL_FEAT0;
         `CQT_OFS_FEAT1:      data = `CQT_VAL_FEAT1;
         `CQT_OFS_FEAT2:      data = `CQT_VAL_FEAT2;
         `CQT_OFS_FEAT3:      data = `CQT_VAL_FEAT3;
         // reserved region slots and anything unlisted read zero
         default:             data = `CQT_VAL_RSVD;
      endcase
   end
endmodule : cqt_rom

// ---- cqt_query_table.sv ----
`timescale 1ns/1ns
`include "cqt_map.svh"
module cqt_query_table
   import cqt_pkg::*;
(
   input  wire logic      clk,
   input  wire logic      rst_n,
   input  wire logic      cmdWrite,
   input  wire cqt_byte_t cmdData,
   input  wire logic      readReq,
   input  wire cqt_ofs_t  readOfs,
   input  wire cqt_word_t arrayData,
   output cqt_word_t      dataOut_r,
   output logic           dataValid_r,
   output logic           queryMode_r
);
   cqt_mode_t mode_r;
   cqt_mode_t mode_nxt;
   cqt_byte_t romByte;
   cqt_word_t dataOut_nxt;

   cqt_rom u_rom (
      .ofs  (readOfs),
      .data (romByte)
   );

   // mode changes only on a command write; other command codes leave it alone
   always_comb begin
      mode_nxt = mode_r;
      if (cmdWrite) begin
         case (cmdData)
            `CQT_CMD_QUERY:      mode_nxt = CQT_QUERY;
            `CQT_CMD_READ_ARRAY: mode_nxt = CQT_ARRAY;
            default:             mode_nxt = mode_r;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         mode_r <= CQT_ARRAY;
      end else begin
         mode_r <= mode_nxt;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         queryMode_r <= 1'b0;
      end else begin
         queryMode_r <= (mode_nxt == CQT_QUERY);
      end
   end

   // read uses the mode in force when the read is taken
   always_comb begin
      case (mode_r)
         CQT_QUERY: dataOut_nxt = {8'h00, romByte};
         CQT_ARRAY: dataOut_nxt = arrayData;
         default:   dataOut_nxt = 16'h0000;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         dataOut_r   <= 16'h0000;
         dataValid_r <= 1'b0;
      end else begin
         dataValid_r <= readReq;
         if (readReq) begin
            dataOut_r <= dataOut_nxt;
         end
      end
   end

   // helper: previous-cycle request context
   logic     wasQuery_r;
   cqt_ofs_t lastOfs_r;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wasQuery_r <= 1'b0;
         lastOfs_r  <= 9'h000;
      end else begin
         wasQuery_r <= (mode_r == CQT_QUERY);
         lastOfs_r  <= readOfs;
      end
   end

   property p_query_enter;
      @(posedge clk) disable iff (!rst_n)
         (cmdWrite && cmdData == 8'h98) |=> queryMode_r;
   endproperty
   a_query_enter: assert property (p_query_enter) else $error("query mode not entered");

   property p_query_exit;
      @(posedge clk) disable iff (!rst_n)
         (cmdWrite && cmdData == 8'hFF) |=> !queryMode_r;
   endproperty
   a_query_exit: assert property (p_query_exit) else $error("query mode not left");

   property p_upper_zero;
      @(posedge clk) disable iff (!rst_n)
         (readReq && mode_r == CQT_QUERY) |=> (dataValid_r && dataOut_r[15:8] == 8'h00);
   endproperty
   a_upper_zero: assert property (p_upper_zero) else $error("upper query byte not zero");

   property p_array_pass;
      @(posedge clk) disable iff (!rst_n)
         (readReq && mode_r == CQT_ARRAY) |=> dataOut_r == $past(arrayData);
   endproperty
   a_array_pass: assert property (p_array_pass) else $error("array data not passed");

   property p_core_supply;
      @(posedge clk) disable iff (!rst_n)
         (readReq && mode_r == CQT_QUERY && readOfs == 9'h01B) |=> dataOut_r == 16'h0017;
   endproperty
   a_core_supply: assert property (p_core_supply) else $error("core supply min wrong");

   property p_prog_supply;
      @(posedge clk) disable iff (!rst_n)
         (readReq && mode_r == CQT_QUERY && readOfs == 9'h01E) |=> dataOut_r == 16'h0095;
   endproperty
   a_prog_supply: assert property (p_prog_supply) else $error("prog supply max wrong");

   property p_blk_typ;
      @(posedge clk) disable iff (!rst_n)
         (readReq && mode_r == CQT_QUERY && readOfs == 9'h021) |=> dataOut_r == 16'h000A;
   endproperty
   a_blk_typ: assert property (p_blk_typ) else $error("block erase typical wrong");

   property p_chip_zero;
      @(posedge clk) disable iff (!rst_n)
         (readReq && mode_r == CQT_QUERY && (readOfs == 9'h022 || readOfs == 9'h026))
         |=> dataOut_r == 16'h0000;
   endproperty
   a_chip_zero: assert property (p_chip_zero) else $error("chip erase entry not zero");

   property p_size;
      @(posedge clk) disable iff (!rst_n)
         (readReq && mode_r == CQT_QUERY && readOfs == 9'h027) |=> dataOut_r == 16'h0018;
   endproperty
   a_size: assert property (p_size) else $error("device size wrong");

   property p_r1_count;
      @(posedge clk) disable iff (!rst_n)
         (readReq && mode_r == CQT_QUERY && readOfs == 9'h02D) |=> dataOut_r == 16'h007E;
   endproperty
   a_r1_count: assert property (p_r1_count) else $error("region one count wrong");

   property p_rsvd;
      @(posedge clk) disable iff (!rst_n)
         (readReq && mode_r == CQT_QUERY && readOfs >= 9'h035 && readOfs <= 9'h038)
         |=> dataOut_r == 16'h0000;
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved region not zero");

   property p_signature;
      @(posedge clk) disable iff (!rst_n)
         (readReq && mode_r == CQT_QUERY && readOfs == 9'h10A) |=> dataOut_r == 16'h0050;
   endproperty
   a_signature: assert property (p_signature) else $error("signature wrong");

   property p_feature;
      @(posedge clk) disable iff (!rst_n)
         (readReq && mode_r == CQT_QUERY && readOfs == 9'h10F) |=> dataOut_r == 16'h00E6;
   endproperty
   a_feature: assert property (p_feature) else $error("feature low byte wrong");

   property p_feature_hi;
      @(posedge clk) disable iff (!rst_n)
         (dataValid_r && wasQuery_r && lastOfs_r == 9'h110) |-> dataOut_r == 16'h0003;
   endproperty
   a_feature_hi: assert property (p_feature_hi) else $error("feature bits above 9 set");

   property p_core_max;
      @(posedge clk) disable iff (!rst_n)
         (readReq && mode_r == CQT_QUERY && readOfs == 9'h01C) |=> dataOut_r == 16'h0020;
   endproperty
   a_core_max: assert property (p_core_max) else $error("core supply max wrong");

   property p_prog_min;
      @(posedge clk) disable iff (!rst_n)
         (readReq && mode_r == CQT_QUERY && readOfs == 9'h01D) |=> dataOut_r == 16'h0085;
   endproperty
   a_prog_min: assert property (p_prog_min) else $error("prog supply min wrong");

   property p_word_typ;
      @(posedge clk) disable iff (!rst_n)
         (readReq && mode_r == CQT_QUERY && readOfs == 9'h01F) |=> dataOut_r == 16'h0004;
   endproperty
   a_word_typ: assert property (p_word_typ) else $error("word program typical wrong");

   property p_buf_typ;
      @(posedge clk) disable iff (!rst_n)
         (readReq && mode_r == CQT_QUERY && readOfs == 9'h020) |=> dataOut_r == 16'h0009;
   endproperty
   a_buf_typ: assert property (p_buf_typ) else $error("buffer program typical wrong");

   property p_word_max;
      @(posedge clk) disable iff (!rst_n)
         (readReq && mode_r == CQT_QUERY && readOfs == 9'h023) |=> dataOut_r == 16'h0004;
   endproperty
   a_word_max: assert property (p_word_max) else $error("word program factor wrong");

   property p_buf_max;
      @(posedge clk) disable iff (!rst_n)
         (readReq && mode_r == CQT_QUERY && readOfs == 9'h024) |=> dataOut_r == 16'h0004;
   endproperty
   a_buf_max: assert property (p_buf_max) else $error("buffer program factor wrong");

   property p_blk_max;
      @(posedge clk) disable iff (!rst_n)
         (readReq && mode_r == CQT_QUERY && readOfs == 9'h025) |=> dataOut_r == 16'h0002;
   endproperty
   a_blk_max: assert property (p_blk_max) else $error("block erase factor wrong");

   property p_ifc;
      @(posedge clk) disable iff (!rst_n)
         (readReq && mode_r == CQT_QUERY && (readOfs == 9'h028 || readOfs == 9'h029))
         |=> dataOut_r == 16'h0001;
   endproperty
   a_ifc: assert property (p_ifc) else $error("interface code wrong");

   property p_wbuf_lo;
      @(posedge clk) disable iff (!rst_n)
         (readReq && mode_r == CQT_QUERY && readOfs == 9'h02A) |=> dataOut_r == 16'h0006;
   endproperty
   a_wbuf_lo: assert property (p_wbuf_lo) else $error("write buffer low wrong");

   property p_wbuf_hi;
      @(posedge clk) disable iff (!rst_n)
         (readReq && mode_r == CQT_QUERY && readOfs == 9'h02B) |=> dataOut_r == 16'h0000;
   endproperty
   a_wbuf_hi: assert property (p_wbuf_hi) else $error("write buffer high wrong");

   property p_regions;
      @(posedge clk) disable iff (!rst_n)
         (readReq && mode_r == CQT_QUERY && readOfs == 9'h02C) |=> dataOut_r == 16'h0002;
   endproperty
   a_regions: assert property (p_regions) else $error("region count wrong");

   property p_r1_count_hi;
      @(posedge clk) disable iff (!rst_n)
         (readReq && mode_r == CQT_QUERY && readOfs == 9'h02E) |=> dataOut_r == 16'h0000;
   endproperty
   a_r1_count_hi: assert property (p_r1_count_hi) else $error("region one count high wrong");

   property p_r1_size_lo;
      @(posedge clk) disable iff (!rst_n)
         (readReq && mode_r == CQT_QUERY && readOfs == 9'h02F) |=> dataOut_r == 16'h0000;
   endproperty
   a_r1_size_lo: assert property (p_r1_size_lo) else $error("region one size low wrong");

   property p_r1_size_hi;
      @(posedge clk) disable iff (!rst_n)
         (readReq && mode_r == CQT_QUERY && readOfs == 9'h030) |=> dataOut_r == 16'h0002;
   endproperty
   a_r1_size_hi: assert property (p_r1_size_hi) else $error("region one size high wrong");

   property p_r2_count;
      @(posedge clk) disable iff (!rst_n)
         (readReq && mode_r == CQT_QUERY && readOfs == 9'h031) |=> dataOut_r == 16'h0003;
   endproperty
   a_r2_count: assert property (p_r2_count) else $error("region two count wrong");

   property p_r2_count_hi;
      @(posedge clk) disable iff (!rst_n)
         (readReq && mode_r == CQT_QUERY && readOfs == 9'h032) |=> dataOut_r == 16'h0000;
   endproperty
   a_r2_count_hi: assert property (p_r2_count_hi) else $error("region two count high wrong");

   property p_r2_size_lo;
      @(posedge clk) disable iff (!rst_n)
         (readReq && mode_r == CQT_QUERY && readOfs == 9'h033) |=> dataOut_r == 16'h0080;
   endproperty
   a_r2_size_lo: assert property (p_r2_size_lo) else $error("region two size low wrong");

   property p_r2_size_hi;
      @(posedge clk) disable iff (!rst_n)
         (readReq && mode_r == CQT_QUERY && readOfs == 9'h034) |=> dataOut_r == 16'h0000;
   endproperty
   a_r2_size_hi: assert property (p_r2_size_hi) else $error("region two size high wrong");

   property p_signature1;
      @(posedge clk) disable iff (!rst_n)
         (readReq && mode_r == CQT_QUERY && readOfs == 9'h10B) |=> dataOut_r == 16'h0052;
   endproperty
   a_signature1: assert property (p_signature1) else $error("signature second word wrong");

   property p_signature2;
      @(posedge clk) disable iff (!rst_n)
         (readReq && mode_r == CQT_QUERY && readOfs == 9'h10C) |=> dataOut_r == 16'h0049;
   endproperty
   a_signature2: assert property (p_signature2) else $error("signature third word wrong");

   property p_ver_major;
      @(posedge clk) disable iff (!rst_n)
         (readReq && mode_r == CQT_QUERY && readOfs == 9'h10D) |=> dataOut_r == 16'h0031;
   endproperty
   a_ver_major: assert property (p_ver_major) else $error("major version wrong");

   property p_ver_minor;
      @(posedge clk) disable iff (!rst_n)
         (readReq && mode_r == CQT_QUERY && readOfs == 9'h10E) |=> dataOut_r == 16'h0033;
   endproperty
   a_ver_minor: assert property (p_ver_minor) else $error("minor version wrong");

   property p_feature_top;
      @(posedge clk) disable iff (!rst_n)
         (readReq && mode_r == CQT_QUERY && (readOfs == 9'h111 || readOfs == 9'h112))
         |=> dataOut_r == 16'h0000;
   endproperty
   a_feature_top: assert property (p_feature_top) else $error("feature upper bytes not zero");

   property p_mode_hold;
      @(posedge clk) disable iff (!rst_n)
         !cmdWrite |=> queryMode_r == $past(queryMode_r);
   endproperty
   a_mode_hold: assert property (p_mode_hold) else $error("mode changed without command");

endmodule : cqt_query_table

// ---- cqt_host_model.sv ----
`timescale 1ns/1ns
module cqt_host_model
   import cqt_pkg::*;
(
   input  wire logic      clk,
   output logic           cmdWrite,
   output cqt_byte_t      cmdData,
   output logic           readReq,
   output cqt_ofs_t       readOfs,
   output cqt_word_t      arrayData,
   input  wire cqt_word_t dataOut_r,
   input  wire logic      dataValid_r
);
   cqt_word_t gotData[$];
   logic      gotValid[$];
   initial begin
      cmdWrite  = 1'b0;
      cmdData   = 8'h00;
      readReq   = 1'b0;
      readOfs   = 9'h000;
      arrayData = 16'h0000;
   end
   // entered just after a falling edge; query code must precede table reads
   task sendCmd(input cqt_byte_t code);
      cmdWrite = 1'b1;
      cmdData  = code;
      @(negedge clk);
      cmdWrite = 1'b0;
      cmdData  = ~code;
      @(negedge clk);
   endtask : sendCmd
   // back-to-back reads, optional command in the first cycle
   task readSeq(input cqt_ofs_t ofsQ[$], input cqt_word_t arrQ[$], input logic withCmd, input cqt_byte_t code);
      gotData  = {};
      gotValid = {};
      cmdWrite = withCmd;
      cmdData  = code;
      foreach (ofsQ[i]) begin
         readReq   = 1'b1;
         readOfs   = ofsQ[i];
         arrayData = arrQ[i];
         @(negedge clk);
         cmdWrite = 1'b0;
         gotData.push_back(dataOut_r);
         gotValid.push_back(dataValid_r);
      end
      // released lines flip so stale values never look valid
      readReq   = 1'b0;
      readOfs   = ~readOfs;
      arrayData = ~arrayData;
      cmdData   = ~code;
      @(negedge clk);
      gotValid.push_back(dataValid_r);
   endtask : readSeq
endmodule : cqt_host_model

// ---- tb_cqt_query_table.sv ----
`timescale 1ns/1ns
module tb_cqt_query_table
   import cqt_pkg::*;
;
   logic      clk;
   logic      rst_n;
   logic      cmdWrite;
   cqt_byte_t cmdData;
   logic      readReq;
   cqt_ofs_t  readOfs;
   cqt_word_t arrayData;
   cqt_word_t dataOut_r;
   logic      dataValid_r;
   logic      queryMode_r;
   int        numErrors;
   int        checksDone;
   int        cycles;
   cqt_ofs_t  ofsQ[$];
   cqt_word_t arrQ[$];
   cqt_word_t mask32[2];
   cqt_byte_t code;
   localparam cqt_byte_t SYS_TAB [26] = '{
      8'h17, 8'h20, 8'h85, 8'h95,
      8'h04, 8'h09, 8'h0A, 8'h00,
      8'h04, 8'h04, 8'h02, 8'h00,
      8'h18, 8'h01, 8'h01,
      8'h06, 8'h00, 8'h02,
      8'h7E, 8'h00, 8'h00, 8'h02,
      8'h03, 8'h00, 8'h80, 8'h00};
   localparam cqt_byte_t EXT_TAB [9] = '{
      8'h50, 8'h52, 8'h49, 8'h31, 8'h33,
      8'hE6, 8'h03, 8'h00, 8'h00};

   cqt_query_table DUT (.clk(clk), .rst_n(rst_n), .cmdWrite(cmdWrite), .cmdData(cmdData), .readReq(readReq),
      .readOfs(readOfs), .arrayData(arrayData), .dataOut_r(dataOut_r), .dataValid_r(dataValid_r),
      .queryMode_r(queryMode_r));
   cqt_host_model host (.clk(clk), .cmdWrite(cmdWrite), .cmdData(cmdData), .readReq(readReq),
      .readOfs(readOfs), .arrayData(arrayData), .dataOut_r(dataOut_r), .dataValid_r(dataValid_r));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   function automatic cqt_word_t expQuery(input cqt_ofs_t o);
      if (o >= 9'h01B && o <= 9'h034) return {8'h00, SYS_TAB[o - 9'h01B]};
      if (o >= 9'h10A && o <= 9'h112) return {8'h00, EXT_TAB[o - 9'h10A]};
      return 16'h0000;
   endfunction : expQuery

   task checkWord(input string what, input cqt_word_t exp, input cqt_word_t got);
      checksDone++;
      if (got !== exp) begin
         numErrors++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask : checkWord
   task checkBit(input string what, input logic exp, input logic got);
      checksDone++;
      if (got !== exp) begin
         numErrors++;
         $display("FAIL %s expected %b seen %b", what, exp, got);
      end
   endtask : checkBit

   task automatic addRand(input int n, input int lo, input int span);
      repeat (n) begin
         ofsQ.push_back(cqt_ofs_t'(lo + $urandom % span));
         arrQ.push_back(cqt_word_t'($urandom));
      end
   endtask : addRand
   task automatic addRange(input int lo, input int hi);
      for (int o = lo; o <= hi; o++) begin
         ofsQ.push_back(cqt_ofs_t'(o));
         arrQ.push_back(cqt_word_t'($urandom));
      end
   endtask : addRange

   // first read sees the mode before any same-cycle command
   task automatic doReads(input logic m0, input logic m1, input logic withCmd, input cqt_byte_t cmd);
      cqt_word_t e;
      host.readSeq(ofsQ, arrQ, withCmd, cmd);
      foreach (ofsQ[i]) begin
         e = ((i == 0) ? m0 : m1) ? expQuery(ofsQ[i]) : arrQ[i];
         checkWord("read data", e, host.gotData[i]);
         checkBit("read valid", 1'b1, host.gotValid[i]);
      end
      checkBit("valid drop", 1'b0, host.gotValid[ofsQ.size()]);
      ofsQ = {};
      arrQ = {};
   endtask : doReads

   task checkIdle(input string n);
      checkWord("reset data", 16'h0000, dataOut_r);
      checkBit("reset valid", 1'b0, dataValid_r);
      checkBit("reset mode", 1'b0, queryMode_r);
      $display("test %s done", n);
   endtask : checkIdle

   task summarize;
      $display("checks %0d errors %0d", checksDone, numErrors);
      if (numErrors == 0 && checksDone > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : summarize

   // about 150 cycles expected; ceiling leaves wide margin
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         numErrors++;
         summarize();
      end
   end

   initial begin
      rst_n = 1'b0;
      void'($urandom(29996));
      repeat (20) @(negedge clk);
      rst_n = 1'b1;
      checkIdle("reset");
      addRand(6, 0, 512);
      doReads(1'b0, 1'b0, 1'b0, 8'h00);
      $display("test array done");
      addRand(4, 9'h01B, 30);
      doReads(1'b0, 1'b1, 1'b1, 8'h98);
      checkBit("mode query", 1'b1, queryMode_r);
      $display("test enter done");
      addRange(9'h01A, 9'h039);
      addRange(9'h109, 9'h113);
      doReads(1'b1, 1'b1, 1'b0, 8'h00);
      $display("test sweep done");
      addRange(9'h10F, 9'h112);
      doReads(1'b1, 1'b1, 1'b0, 8'h00);
      mask32[0] = {host.gotData[1][7:0], host.gotData[0][7:0]};
      mask32[1] = {host.gotData[3][7:0], host.gotData[2][7:0]};
      checkWord("mask low", 16'h03E6, mask32[0]);
      checkWord("mask high", 16'h0000, mask32[1]);
      $display("test mask done");
      addRand(40, 0, 512);
      doReads(1'b1, 1'b1, 1'b0, 8'h00);
      $display("test random done");
      repeat (6) begin
         code = cqt_byte_t'($urandom);
         if (code == 8'h98 || code == 8'hFF) code = 8'h00;
         host.sendCmd(code);
         checkBit("mode kept", 1'b1, queryMode_r);
      end
      $display("test ignore done");
      addRand(3, 9'h10A, 9);
      doReads(1'b1, 1'b0, 1'b1, 8'hFF);
      checkBit("mode array", 1'b0, queryMode_r);
      $display("test leave done");
      host.sendCmd(8'h98);
      addRange(9'h01B, 9'h01B);
      doReads(1'b1, 1'b1, 1'b0, 8'h00);
      rst_n = 1'b0;
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      checkIdle("midreset");
      addRand(2, 9'h01B, 26);
      doReads(1'b0, 1'b0, 1'b0, 8'h00);
      $display("test postreset done");
      summarize();
   end
endmodule : tb_cqt_query_table
